// ==== testbench/ptp_egress_checker.sv ====
/*
  Port-level assertions for the egress stamp and asymmetry block.
  Assumes one clock, active-high async reset, bound to the top module.
*/
`timescale 1ns/1ps
module ptp_egress_checker
  import ptp_egress_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire logic              tx_stamp_valid,
  input wire logic [2:0]        tx_stamp_port,
  input wire logic [1:0]        tx_stamp_kind,
  input wire logic              corr_in_valid,
  input wire logic              corr_in_egress,
  input wire logic [3:0]        corr_in_msg_type,
  input wire logic [CORR_W-1:0] corr_in_field,
  input wire logic              corr_out_valid,
  input wire logic [CORR_W-1:0] corr_out_field,
  input wire logic [PORTS-1:0]  stamp_status_summary,
  input wire logic [PORTS-1:0]  stamp_enable_summary,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cap;
    tx_stamp_valid && tx_stamp_port != 3'h0 && tx_stamp_kind != 2'h3;
  endsequence
  a_ready_single: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not a single access cycle");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_stamp_summary: assert property (s_cap |=> ##1 stamp_status_summary[$past(tx_stamp_port, 2) - 3'h1])
    else $error("summary missing after capture");
  a_irq_masked: assert property (irq |-> |(stamp_status_summary & stamp_enable_summary))
    else $error("irq without enabled flag");
  a_corr_valid: assert property (corr_in_valid |=> corr_out_valid)
    else $error("correction result missing");
  a_corr_idle: assert property (!corr_in_valid |=> !corr_out_valid)
    else $error("spurious correction result");
  a_corr_pass: assert property (corr_in_valid && corr_in_egress && corr_in_msg_type == MSG_SYNC
    |=> corr_out_field == $past(corr_in_field))
    else $error("sent sync field altered");
endmodule // ptp_egress_checker

bind ptp_port_egress_timestamp ptp_egress_checker #(.PORTS(PORTS)) u_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .tx_stamp_valid(tx_stamp_valid),
  .tx_stamp_port(tx_stamp_port), .tx_stamp_kind(tx_stamp_kind),
  .corr_in_valid(corr_in_valid), .corr_in_egress(corr_in_egress),
  .corr_in_msg_type(corr_in_msg_type), .corr_in_field(corr_in_field),
  .corr_out_valid(corr_out_valid), .corr_out_field(corr_out_field),
  .stamp_status_summary(stamp_status_summary),
  .stamp_enable_summary(stamp_enable_summary), .irq(irq));

// ==== testbench/test_ptp_port_egress_timestamp.sv ====
/*
  Self-checking bench for the egress stamp block: APB registers,
  stamp capture, status and interrupt, correction path.
  Assumes the block answers APB with zero wait states.
*/
`timescale 1ns/1ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %0t %s", $time, m); end end
module test_ptp_port_egress_timestamp
  import ptp_egress_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, tx_stamp_valid, corr_in_valid, corr_in_egress;
  logic        pready, pslverr, corr_out_valid, irq, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, tx_stamp_ns, rd;
  logic [3:0]  pstrb, corr_in_msg_type;
  logic [2:0]  tx_stamp_port, corr_in_port;
  logic [1:0]  tx_stamp_kind;
  logic [63:0] corr_in_field, corr_out_field;
  logic [6:0]  stamp_status_summary, stamp_enable_summary;
  int          fail_count = 0;
  int          check_count = 0;

  ptp_port_egress_timestamp DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_stamp_valid(tx_stamp_valid),
    .tx_stamp_port(tx_stamp_port), .tx_stamp_kind(tx_stamp_kind), .tx_stamp_ns(tx_stamp_ns),
    .corr_in_valid(corr_in_valid), .corr_in_port(corr_in_port),
    .corr_in_egress(corr_in_egress), .corr_in_msg_type(corr_in_msg_type),
    .corr_in_field(corr_in_field), .corr_out_valid(corr_out_valid),
    .corr_out_field(corr_out_field), .stamp_status_summary(stamp_status_summary),
    .stamp_enable_summary(stamp_enable_summary), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cap(input logic [2:0] p, input logic [1:0] k, input logic [31:0] ns);
    @(posedge clk);
    tx_stamp_valid <= 1'b1;
    tx_stamp_port <= p;
    tx_stamp_kind <= k;
    tx_stamp_ns <= ns;
    @(posedge clk);
    tx_stamp_valid <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [11:0] pg [9] = '{IDX_ASYM, IDX_REQ_HI, IDX_REQ_LO, IDX_SYNC_HI, IDX_SYNC_LO,
                            IDX_RESP_HI, IDX_RESP_LO, IDX_STATUS, IDX_ENABLE};
    foreach (pg[i]) begin
      apb(1'b0, {4'h1, pg[i]}, 16'h0000);
      `CHK(rd, 32'h0000_0000, "reset value")
    end
    apb(1'b0, {4'h1, 12'hC06}, 16'h0000);
    `CHK(er, 1'b1, "unmapped")
    apb(1'b0, {4'h0, IDX_ASYM}, 16'h0000);
    `CHK(er, 1'b1, "port zero")
    $display("test reset done");
  endtask

  task automatic t_stamps();
    logic [11:0] hi [3] = '{IDX_SYNC_HI, IDX_REQ_HI, IDX_RESP_HI};
    logic [31:0] ns;
    for (int k = 0; k < 3; k++) begin
      ns = 32'hA5C3_1E7B + k * 32'h0101_1111;
      cap(3'h3, k[1:0], ns);
      apb(1'b0, {4'h3, hi[k]}, 16'h0000);
      `CHK(rd, {16'h0000, ns[31:16]}, "stamp high")
      apb(1'b0, {4'h3, hi[k] + 12'h002}, 16'h0000);
      `CHK(rd, {16'h0000, ns[15:0]}, "stamp low")
      apb(1'b0, {4'h3, IDX_STATUS}, 16'h0000);
      `CHK(rd[15:0], 16'h8000 >> k, "flag")
      apb(1'b1, {4'h3, IDX_STATUS}, 16'h8000 >> k);
      apb(1'b1, {4'h3, hi[k]}, 16'hFFFF);
      apb(1'b0, {4'h3, hi[k]}, 16'h0000);
      `CHK(rd, {16'h0000, ns[31:16]}, "read-only stamp")
      apb(1'b0, {4'h2, hi[k]}, 16'h0000);
      `CHK(rd, 32'h0000_0000, "other port")
    end
    apb(1'b0, {4'h3, IDX_STATUS}, 16'h0000);
    `CHK(rd, 32'h0000_0000, "flags cleared")
    $display("test stamps done");
  endtask

  task automatic t_irq();
    cap(3'h4, KIND_SYNC, 32'h1);
    cap(3'h4, KIND_REQ, 32'h2);
    cap(3'h4, KIND_RESP, 32'h3);
    apb(1'b0, {4'h4, IDX_STATUS}, 16'h0000);
    `CHK(rd, 32'h0000_E000, "all flags")
    `CHK(stamp_status_summary, 7'h08, "status summary")
    `CHK(irq, 1'b0, "irq masked")
    apb(1'b1, {4'h4, IDX_ENABLE}, 16'hFFFF);
    settle();
    `CHK(irq, 1'b1, "irq enabled")
    `CHK(stamp_enable_summary, 7'h08, "enable summary")
    apb(1'b0, {4'h4, IDX_ENABLE}, 16'h0000);
    `CHK(rd, 32'h0000_E000, "enable bits")
    apb(1'b1, {4'h4, IDX_STATUS}, 16'h0000);
    apb(1'b0, {4'h4, IDX_STATUS}, 16'h0000);
    `CHK(rd, 32'h0000_E000, "zero write")
    apb(1'b1, {4'h4, IDX_STATUS}, 16'h8000);
    apb(1'b0, {4'h4, IDX_STATUS}, 16'h0000);
    `CHK(rd, 32'h0000_6000, "sync clear")
    apb(1'b1, {4'h4, IDX_STATUS}, 16'h6000);
    settle();
    `CHK(stamp_status_summary, 7'h00, "summary clear")
    `CHK(irq, 1'b0, "irq clear")
    $display("test irq done");
  endtask

  task automatic t_corr();
    logic [15:0] av [2] = '{16'h0123, 16'h8123};
    logic [63:0] f, d, e;
    foreach (av[a]) begin
      apb(1'b1, {4'h5, IDX_ASYM}, av[a]);
      apb(1'b0, {4'h5, IDX_ASYM}, 16'h0000);
      `CHK(rd, {16'h0000, av[a]}, "asymmetry")
      d = {33'h0, av[a][14:0], 16'h0000};
      if (av[a][15]) d = -d;
      for (int m = 0; m < 4; m++) begin
        for (int g = 0; g < 2; g++) begin
          f = 64'h0000_0100_0000_0000;
          e = f;
          if (g == 0 && (m[3:0] == MSG_SYNC || m[3:0] == MSG_PDELAY_RSP)) e = f + d;
          if (g == 1 && (m[3:0] == MSG_DELAY_REQ || m[3:0] == MSG_PDELAY_REQ)) e = f - d;
          @(posedge clk);
          corr_in_valid <= 1'b1;
          corr_in_port <= 3'h5;
          corr_in_egress <= g[0];
          corr_in_msg_type <= m[3:0];
          corr_in_field <= f;
          @(posedge clk);
          corr_in_valid <= 1'b0;
          #1;
          `CHK(corr_out_field, e, "corrected field")
          `CHK(corr_out_valid, 1'b1, "correction valid")
        end
      end
    end
    pstrb <= 4'h2;
    apb(1'b1, {4'h5, IDX_ASYM}, 16'h4455);
    pstrb <= 4'hF;
    apb(1'b0, {4'h5, IDX_ASYM}, 16'h0000);
    `CHK(rd, 32'h0000_4423, "upper lane only")
    $display("test corr done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {rst, psel, penable, pwrite, tx_stamp_valid, corr_in_valid, corr_in_egress} = 7'h40;
    {paddr, pwdata, tx_stamp_ns, corr_in_field} = '0;
    {pstrb, corr_in_msg_type, tx_stamp_port, corr_in_port, tx_stamp_kind} = 16'hF000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stamps();
    t_irq();
    t_corr();
    wrap_up();
  end

  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule // test_ptp_port_egress_timestamp

// ==== verilog/ptp_egress_pkg.sv ====
/*
  Constants for the per-port egress timestamp and asymmetry block:
  register indices, field positions, reset values and message codes.
  Assumes a word-per-register APB map where byte address = 4 * index.
*/
package ptp_egress_pkg;

  // Ports 1..NUM_PORTS; port number sits in index bits 15:12
  localparam int          NUM_PORTS      = 7;
  localparam int          PORT_LSB       = 12;
  localparam int          IDX_W          = 16;
  localparam int          ADDR_W         = 18;

  // Register indices within a port page
  localparam logic [11:0] IDX_ASYM       = 12'hC04;
  localparam logic [11:0] IDX_REQ_HI     = 12'hC08;
  localparam logic [11:0] IDX_REQ_LO     = 12'hC0A;
  localparam logic [11:0] IDX_SYNC_HI    = 12'hC0C;
  localparam logic [11:0] IDX_SYNC_LO    = 12'hC0E;
  localparam logic [11:0] IDX_RESP_HI    = 12'hC10;
  localparam logic [11:0] IDX_RESP_LO    = 12'hC12;
  localparam logic [11:0] IDX_STATUS     = 12'hC14;
  localparam logic [11:0] IDX_ENABLE     = 12'hC16;

  // Field positions
  localparam int          SIGN_BIT       = 15;
  localparam int          MAG_MSB        = 14;
  localparam int          SYNC_FLAG_BIT  = 15;
  localparam int          REQ_FLAG_BIT   = 14;
  localparam int          RESP_FLAG_BIT  = 13;

  // Reset values
  localparam logic [15:0] ASYM_RST       = 16'h0000;
  localparam logic [31:0] STAMP_RST      = 32'h0000_0000;
  localparam logic [2:0]  FLAG_RST       = 3'h0;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // Egress stamp kinds on the capture port
  localparam logic [1:0]  KIND_SYNC      = 2'h0;
  localparam logic [1:0]  KIND_REQ       = 2'h1;
  localparam logic [1:0]  KIND_RESP      = 2'h2;

  // Message type codes on the correction port
  localparam logic [3:0]  MSG_SYNC       = 4'h0;
  localparam logic [3:0]  MSG_DELAY_REQ  = 4'h1;
  localparam logic [3:0]  MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0]  MSG_PDELAY_RSP = 4'h3;

  // Correction field carries ns scaled by 2^16
  localparam int          CORR_FRAC_BITS = 16;
  localparam int          CORR_W         = 64;

endpackage

// ==== verilog/ptp_port_egress_timestamp.sv ====
/*
  Per-port PTP egress timestamp capture, asymmetry correction and
  timestamp status for switch ports 1..7, behind an APB slave.
  Assumes one clock for APB, stamp capture and correction paths;
  stamp and correction inputs come from logic on that clock.
*/
// What this block does
// - Asymmetry bit 15 is the sign; 1 means negative magnitude.
// - Add signed asymmetry to correction of received Sync and Pdelay_Resp.
// - Subtract signed asymmetry from correction of sent Delay_Req, Pdelay_Req.
// - Request egress stamp readable as high and low read-only halves.
// - Sync egress stamp readable as high and low read-only halves.
// - Peer response egress stamp readable as high and low halves.
// - Status bit 15 sets on Sync stamp; write one clears it.
// - Status bit 14 sets on request stamp; write one clears it.
// - Status bit 13 sets on response stamp; write one clears it.
// - Per-port status summary is the OR of the three flags.
// - Enable bits 15..13 match the flags and OR into a summary.
`timescale 1ns/1ps
module ptp_port_egress_timestamp
  import ptp_egress_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Egress stamp capture
  input  wire logic                tx_stamp_valid,
  input  wire logic [2:0]          tx_stamp_port,
  input  wire logic [1:0]          tx_stamp_kind,
  input  wire logic [31:0]         tx_stamp_ns,
  // Correction field update path
  input  wire logic                corr_in_valid,
  input  wire logic [2:0]          corr_in_port,
  input  wire logic                corr_in_egress,
  input  wire logic [3:0]          corr_in_msg_type,
  input  wire logic [CORR_W-1:0]   corr_in_field,
  output logic                     corr_out_valid,
  output logic      [CORR_W-1:0]   corr_out_field,
  // Per-port summaries, bit i-1 is port i
  output logic      [PORTS-1:0]    stamp_status_summary,
  output logic      [PORTS-1:0]    stamp_enable_summary,
  output logic                     irq
);

  // Signed asymmetry in correction-field units
  function automatic logic [CORR_W-1:0] asym_delta(input logic [15:0] asym);
    logic [CORR_W-1:0] mag;
    mag = {{(CORR_W-MAG_MSB-1-CORR_FRAC_BITS){1'b0}}, asym[MAG_MSB:0],
           {CORR_FRAC_BITS{1'b0}}};
    return asym[SIGN_BIT] ? (~mag + {{(CORR_W-1){1'b0}}, 1'b1}) : mag;
  endfunction

  // Port number check; true only for 1..PORTS
  function automatic logic port_ok(input logic [3:0] num);
    return (num != 4'h0) && ({28'h0, num} <= PORTS);
  endfunction

  // APB decode
  wire logic [IDX_W-1:0] idx        = paddr[ADDR_W-1:2];
  wire logic [3:0]       idx_port   = idx[IDX_W-1:PORT_LSB];
  wire logic [11:0]      idx_page   = idx[PORT_LSB-1:0];
  wire logic             aligned    = (paddr[1:0] == 2'h0);
  wire logic             setup_ph   = psel && !penable;
  wire logic             access_ok  = psel && penable && pready;
  wire logic             wr_commit  = access_ok && pwrite && !pslverr;
  wire logic             hit_asym   = (idx_page == IDX_ASYM);
  wire logic             hit_status = (idx_page == IDX_STATUS);
  wire logic             hit_enable = (idx_page == IDX_ENABLE);
  wire logic             hit_stamp  = (idx_page == IDX_REQ_HI)  || (idx_page == IDX_REQ_LO)
                                   || (idx_page == IDX_SYNC_HI) || (idx_page == IDX_SYNC_LO)
                                   || (idx_page == IDX_RESP_HI) || (idx_page == IDX_RESP_LO);
  wire logic             hit_any    = hit_asym || hit_status || hit_enable || hit_stamp;
  wire logic             mapped     = aligned && port_ok(idx_port) && hit_any;
  wire logic [2:0]       sel_slot   = idx_port[2:0] - 3'h1;

  // Per-port register views
  logic [15:0] asym_v   [PORTS];
  logic [31:0] req_v    [PORTS];
  logic [31:0] sync_v   [PORTS];
  logic [31:0] resp_v   [PORTS];
  logic [2:0]  flags_v  [PORTS];
  logic [2:0]  ens_v    [PORTS];
  logic [PORTS-1:0] ssum_w;
  logic [PORTS-1:0] esum_w;
  logic [PORTS-1:0] irq_w;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    wire logic port_hit = mapped && (sel_slot == 3'(p));
    wire logic cap_hit  = tx_stamp_valid && (tx_stamp_port == 3'(p + 1));

    // Independent register set per port
    ptp_port_slice u_slice (
      .clk           (clk),
      .rst           (rst),
      .wr_asym       (wr_commit && port_hit && hit_asym),
      .wr_be         (pstrb[1:0]),
      .wr_status     (wr_commit && port_hit && hit_status),
      .wr_enable     (wr_commit && port_hit && hit_enable),
      .wdata         (pwdata[15:0]),
      .cap_valid     (cap_hit),
      .cap_kind      (tx_stamp_kind),
      .cap_ns        (tx_stamp_ns),
      .asym_ff       (asym_v[p]),
      .req_stamp_ff  (req_v[p]),
      .sync_stamp_ff (sync_v[p]),
      .resp_stamp_ff (resp_v[p]),
      .flags_ff      (flags_v[p]),
      .enables_ff    (ens_v[p]),
      .status_sum_ff (ssum_w[p]),
      .enable_sum_ff (esum_w[p]),
      .irq_ff        (irq_w[p])
    );
  end

  // Read selection for the addressed port
  wire logic [15:0] rd_asym  = asym_v[sel_slot];
  wire logic [31:0] rd_req   = req_v[sel_slot];
  wire logic [31:0] rd_sync  = sync_v[sel_slot];
  wire logic [31:0] rd_resp  = resp_v[sel_slot];
  wire logic [15:0] rd_flags = {flags_v[sel_slot], 13'h0000};
  wire logic [15:0] rd_ens   = {ens_v[sel_slot], 13'h0000};
  logic [15:0] rd_word;

  always_comb begin
    case (idx_page)
      IDX_ASYM:    rd_word = rd_asym;
      IDX_REQ_HI:  rd_word = rd_req[31:16];
      IDX_REQ_LO:  rd_word = rd_req[15:0];
      IDX_SYNC_HI: rd_word = rd_sync[31:16];
      IDX_SYNC_LO: rd_word = rd_sync[15:0];
      IDX_RESP_HI: rd_word = rd_resp[31:16];
      IDX_RESP_LO: rd_word = rd_resp[15:0];
      IDX_STATUS:  rd_word = rd_flags;
      IDX_ENABLE:  rd_word = rd_ens;
      default:     rd_word = 16'h0000;
    endcase
  end

  // APB answer: one access cycle, no waits
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic [31:0] nxt_prdata;

  assign nxt_pready  = setup_ph;
  assign nxt_pslverr = setup_ph && !mapped;
  assign nxt_prdata  = (setup_ph && mapped && !pwrite) ? {16'h0000, rd_word} : RDATA_RST;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RDATA_RST;
    end else begin
      pready  <= nxt_pready;
      pslverr <= nxt_pslverr;
      prdata  <= nxt_prdata;
    end
  end

  // Correction update
  wire logic [2:0]        corr_slot  = corr_in_port - 3'h1;
  wire logic              corr_pok   = port_ok({1'b0, corr_in_port});
  wire logic [CORR_W-1:0] corr_delta = asym_delta(asym_v[corr_slot]);
  wire logic              rx_add     = !corr_in_egress
                                    && ((corr_in_msg_type == MSG_SYNC)
                                     || (corr_in_msg_type == MSG_PDELAY_RSP));
  wire logic              tx_sub     = corr_in_egress
                                    && ((corr_in_msg_type == MSG_DELAY_REQ)
                                     || (corr_in_msg_type == MSG_PDELAY_REQ));
  logic [CORR_W-1:0] nxt_corr_field;

  always_comb begin
    if (corr_pok && rx_add) begin
      nxt_corr_field = corr_in_field + corr_delta;
    end else if (corr_pok && tx_sub) begin
      nxt_corr_field = corr_in_field - corr_delta;
    end else begin
      nxt_corr_field = corr_in_field;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      corr_out_valid <= 1'b0;
      corr_out_field <= {CORR_W{1'b0}};
    end else begin
      corr_out_valid <= corr_in_valid;
      corr_out_field <= nxt_corr_field;
    end
  end

  // Summaries and interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stamp_status_summary <= {PORTS{1'b0}};
      stamp_enable_summary <= {PORTS{1'b0}};
      irq                  <= 1'b0;
    end else begin
      stamp_status_summary <= ssum_w;
      stamp_enable_summary <= esum_w;
      irq                  <= |irq_w;
    end
  end

endmodule // ptp_port_egress_timestamp

// ==== verilog/ptp_port_slice.sv ====
/*
  One port's register set: asymmetry, three egress stamps, W1C flags,
  enables and the summary / interrupt flops.
  Assumes strobes are single-cycle and on the same clock.
*/
`timescale 1ns/1ps
module ptp_port_slice
  import ptp_egress_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_asym,
  input  wire logic [1:0]  wr_be,
  input  wire logic        wr_status,
  input  wire logic        wr_enable,
  input  wire logic [15:0] wdata,
  input  wire logic        cap_valid,
  input  wire logic [1:0]  cap_kind,
  input  wire logic [31:0] cap_ns,
  output logic      [15:0] asym_ff,
  output logic      [31:0] req_stamp_ff,
  output logic      [31:0] sync_stamp_ff,
  output logic      [31:0] resp_stamp_ff,
  output logic      [2:0]  flags_ff,
  output logic      [2:0]  enables_ff,
  output logic             status_sum_ff,
  output logic             enable_sum_ff,
  output logic             irq_ff
);

  // Flag vector order: [2]=sync, [1]=request, [0]=response
  wire logic       cap_sync = cap_valid && (cap_kind == KIND_SYNC);
  wire logic       cap_req  = cap_valid && (cap_kind == KIND_REQ);
  wire logic       cap_resp = cap_valid && (cap_kind == KIND_RESP);
  wire logic [2:0] set_vec  = {cap_sync, cap_req, cap_resp};
  wire logic [2:0] clr_vec  = wr_status ? wdata[SYNC_FLAG_BIT:RESP_FLAG_BIT] : 3'h0;
  // Set wins over a clear landing in the same cycle
  wire logic [2:0] nxt_flags   = (flags_ff & ~clr_vec) | set_vec;
  wire logic [2:0] nxt_enables = wr_enable ? wdata[SYNC_FLAG_BIT:RESP_FLAG_BIT]
                                           : enables_ff;
  wire logic [15:0] nxt_asym = {wr_be[1] ? wdata[15:8] : asym_ff[15:8],
                                wr_be[0] ? wdata[7:0]  : asym_ff[7:0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asym_ff <= ASYM_RST;
    end else if (wr_asym) begin
      asym_ff <= nxt_asym;
    end
  end

  // Stamp loads before its flag is seen by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_stamp_ff  <= STAMP_RST;
      sync_stamp_ff <= STAMP_RST;
      resp_stamp_ff <= STAMP_RST;
    end else begin
      if (cap_req)  req_stamp_ff  <= cap_ns;
      if (cap_sync) sync_stamp_ff <= cap_ns;
      if (cap_resp) resp_stamp_ff <= cap_ns;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff      <= FLAG_RST;
      enables_ff    <= FLAG_RST;
      status_sum_ff <= 1'b0;
      enable_sum_ff <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      flags_ff      <= nxt_flags;
      enables_ff    <= nxt_enables;
      status_sum_ff <= |nxt_flags;
      enable_sum_ff <= |nxt_enables;
      irq_ff        <= |(nxt_flags & nxt_enables);
    end
  end

endmodule // ptp_port_slice
